//--- verilog/osd_cmd_decoder.sv
// Display command decoder with display memory and dot clock sync sampling
`timescale 1ns/1ps

// Function
// - Group 0 carries row address, fill enable and column address.
// - Group 1 stages character output, background control and colors.
// - Group 2 carries join flag, width select and 10-bit character code.
// - Group 3 stages row height, spacing, trim output, trim control, trim color.
// - Group 4 carries row output, enlargement, join, extension and background fields.
// - Screen subcode 0 sets sprite, screen background, display enables, output A control.
// - Screen subcode 1 sets output B sprite, backgrounds and character control.
// - Screen subcode 2 sets output C sprite, backgrounds and character control.
// - Screen subcode 100 loads nine-bit vertical display position.
// - Screen subcode 110 loads nine-bit horizontal display position.
// - Sprite subcode 00 loads trim control, trim color and sprite color.
// - Sprite subcode 01 loads sprite shape and eight-bit sprite code.
// - Sprite position subcode 00 loads ten-bit sprite vertical position.
// - Sprite position subcode 10 loads ten-bit sprite horizontal position.
// - Active line sync stalls memory writes; host keeps pulses shorter than writes.
// - Polarity select 0 means active-low syncs, 1 active-high.
// - Dot clock runs at one or two times dot rate; syncs sampled on it.
// - Character write stores staged attributes plus fields, then advances address when fill enable is off.
// - Row write stores staged row attributes plus fields, address unchanged.
// - Fill enable makes every character write fill character memory until an address word clears it.
// - Reset clears sprite output, screen background and display output enables.
module osd_cmd_decoder
  import osd_pkg::*;
(
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Decoded serial command words
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic sync_polarity_sel_i,
  // Dot clock and sync pins
  input wire logic dot_clk_in_i,
  input wire logic line_sync_i,
  input wire logic frame_sync_i,
  // Display memory read port
  input wire logic [3:0] rd_row_i,
  input wire logic [4:0] rd_col_i,
  output logic [23:0] rd_char_data_o,
  output logic [23:0] rd_row_data_o,
  // Status
  output logic busy_o,
  output logic line_sync_o,
  output logic frame_sync_o,
  output logic [3:0] wr_row_o,
  output logic [4:0] wr_col_o,
  output logic fill_enable_o,
  // Screen output settings
  output logic sprite_out_en_o,
  output logic screen_bg_en_o,
  output logic display_out_en_o,
  output logic [2:0] out_a_char_ctl_o,
  output logic out_b_sprite_en_o,
  output logic out_b_screen_bg_en_o,
  output logic out_b_row_bg_en_o,
  output logic [2:0] out_b_char_ctl_o,
  output logic out_c_sprite_en_o,
  output logic out_c_screen_bg_en_o,
  output logic out_c_row_bg_en_o,
  output logic [2:0] out_c_char_ctl_o,
  output logic [8:0] vert_position_o,
  output logic [8:0] horiz_position_o,
  // Sprite settings
  output logic [1:0] sprite_trim_ctl_o,
  output logic [3:0] sprite_trim_color_o,
  output logic [3:0] sprite_color_o,
  output logic [1:0] sprite_shape_sel_o,
  output logic [7:0] sprite_code_o,
  output logic [9:0] sprite_vpos_o,
  output logic [9:0] sprite_hpos_o
);

  logic [23:0] char_mem [0:CHAR_CELLS-1];
  logic [23:0] row_mem [0:CHAR_ROWS-1];

  osd_cmd_t cmd;
  osd_addr_cmd_t cmd_addr;
  osd_out_cmd_t cmd_out;
  osd_pos_cmd_t cmd_pos;
  osd_spr_cmd_t cmd_spr;
  osd_state_t state;
  osd_state_t next_state;
  osd_char_attr_t char_attr;
  osd_row_attr_t row_attr;
  logic [11:0] pend_fld;
  logic [8:0] fill_idx;
  logic [8:0] wr_cell;
  logic char_we;
  logic row_we;
  logic [1:0] pol_sync;
  logic [1:0] dot_rst;
  logic [1:0] line_pin;
  logic [1:0] frame_pin;
  logic line_act_dot;
  logic frame_act_dot;
  logic [1:0] line_cdc;
  logic [1:0] frame_cdc;
  logic is_char_write;
  logic is_row_write;

  // Views of the incoming word in each command layout
  assign cmd = osd_cmd_t'(cmd_word_i);
  assign cmd_addr = osd_addr_cmd_t'(cmd_word_i);
  assign cmd_out = osd_out_cmd_t'(cmd_word_i);
  assign cmd_pos = osd_pos_cmd_t'(cmd_word_i);
  assign cmd_spr = osd_spr_cmd_t'(cmd_word_i);
  assign is_char_write = cmd_valid_i && (cmd.grp == GRP_CHAR_WRITE);
  assign is_row_write = cmd_valid_i && (cmd.grp == GRP_ROW_WRITE);
  assign wr_cell = 9'(wr_row_o * COLS_W9) + 9'(wr_col_o);

  // ---------------- Dot clock domain ----------------

  // reset held with dot clocks
  // Release of reset is retimed so sampling starts cleanly on the dot clock
  always_ff @(posedge dot_clk_in_i or posedge rst_i) begin
    if (rst_i) begin
      dot_rst <= DOT_RST_ON;
    end else begin
      dot_rst <= {dot_rst[0], 1'b0};
    end
  end

  // syncs sampled on dot clock
  // Two stages on each sync pin before any logic reads it
  always_ff @(posedge dot_clk_in_i or posedge rst_i) begin
    if (rst_i) begin
      line_pin <= 2'h0;
      frame_pin <= 2'h0;
      pol_sync <= 2'h0;
    end else begin
      line_pin <= {line_pin[0], line_sync_i};
      frame_pin <= {frame_pin[0], frame_sync_i};
      pol_sync <= {pol_sync[0], sync_polarity_sel_i};
    end
  end

  // polarity select swaps levels
  // Active level: low when select is 0, high when select is 1
  always_ff @(posedge dot_clk_in_i or posedge rst_i) begin
    if (rst_i) begin
      line_act_dot <= 1'b0;
      frame_act_dot <= 1'b0;
    end else if (dot_rst[1]) begin
      line_act_dot <= 1'b0;
      frame_act_dot <= 1'b0;
    end else begin
      line_act_dot <= pol_sync[1] ? line_pin[1] : ~line_pin[1];
      frame_act_dot <= pol_sync[1] ? frame_pin[1] : ~frame_pin[1];
    end
  end

  // ---------------- System clock domain ----------------

  // Sync levels cross into the command domain on two flops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_cdc <= 2'h0;
      frame_cdc <= 2'h0;
    end else begin
      line_cdc <= {line_cdc[0], line_act_dot};
      frame_cdc <= {frame_cdc[0], frame_act_dot};
    end
  end

  // Status copies of the retimed sync levels
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_sync_o <= 1'b0;
      frame_sync_o <= 1'b0;
    end else begin
      line_sync_o <= line_cdc[1];
      frame_sync_o <= frame_cdc[1];
    end
  end

  // Write engine next state; a write waits out the line sync pulse
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (is_char_write) begin
          next_state = fill_enable_o ? ST_FILL : ST_PEND_CHAR;
        end else if (is_row_write) begin
          next_state = ST_PEND_ROW;
        end
      end
      ST_PEND_CHAR, ST_PEND_ROW: begin
        if (!line_sync_o) begin
          next_state = ST_IDLE;
        end
      end
      ST_FILL: begin
        if (!line_sync_o && fill_idx == LAST_CELL) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign char_we = !line_sync_o && ((state == ST_PEND_CHAR) || (state == ST_FILL));
  assign row_we = !line_sync_o && (state == ST_PEND_ROW);

  // State and busy flag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      busy_o <= (next_state != ST_IDLE);
    end
  end

  // character write fields captured
  // Write words are captured once; later write words while busy are dropped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_fld <= 12'h000;
    end else if (state == ST_IDLE && (is_char_write || is_row_write)) begin
      pend_fld <= cmd.body;
    end
  end

  // Fill walks every character cell from the first one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fill_idx <= 9'h000;
    end else if (state != ST_FILL) begin
      fill_idx <= 9'h000;
    end else if (!line_sync_o) begin
      fill_idx <= fill_idx + 9'h001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_row_o <= 4'h0;
      wr_col_o <= 5'h00;
      fill_enable_o <= 1'b0;
    end else if (cmd_valid_i && cmd.grp == GRP_ADDR && cmd_addr.zero == 2'h0) begin
      wr_row_o <= cmd_addr.row;
      wr_col_o <= cmd_addr.col;
      fill_enable_o <= cmd_addr.fill;
    end else if (char_we && state == ST_PEND_CHAR) begin
      // advance after character write
      // Column wraps into the next row, last row wraps to the top
      if (wr_col_o >= LAST_COL) begin
        wr_col_o <= 5'h00;
        wr_row_o <= (wr_row_o >= LAST_ROW) ? 4'h0 : wr_row_o + 4'h1;
      end else begin
        wr_col_o <= wr_col_o + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      char_attr <= osd_char_attr_t'(12'h000);
      row_attr <= osd_row_attr_t'(12'h000);
    end else if (cmd_valid_i && cmd.grp == GRP_CHAR_ATTR) begin
      char_attr <= osd_char_attr_t'(cmd.body);
    end else if (cmd_valid_i && cmd.grp == GRP_ROW_ATTR) begin
      row_attr <= osd_row_attr_t'(cmd.body);
    end
  end

  // Character memory; an out-of-range address writes nothing
  always_ff @(posedge clk_i) begin
    if (char_we) begin
      if (state == ST_FILL) begin
        char_mem[fill_idx] <= {char_attr, pend_fld};
      end else if (wr_row_o <= LAST_ROW && wr_col_o <= LAST_COL) begin
        char_mem[wr_cell] <= {char_attr, pend_fld};
      end
    end
  end

  // Row memory; no address change follows
  always_ff @(posedge clk_i) begin
    if (row_we && wr_row_o <= LAST_ROW) begin
      row_mem[wr_row_o] <= {row_attr, pend_fld};
    end
  end

  // Registered read port; out-of-range addresses read zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_char_data_o <= 24'h000000;
      rd_row_data_o <= 24'h000000;
    end else begin
      if (rd_row_i <= LAST_ROW && rd_col_i <= LAST_COL) begin
        rd_char_data_o <= char_mem[9'(rd_row_i * COLS_W9) + 9'(rd_col_i)];
      end else begin
        rd_char_data_o <= 24'h000000;
      end
      rd_row_data_o <= (rd_row_i <= LAST_ROW) ? row_mem[rd_row_i] : 24'h000000;
    end
  end

  // Screen output controls for the three outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sprite_out_en_o <= 1'b0;
      screen_bg_en_o <= 1'b0;
      display_out_en_o <= 1'b0;
      out_a_char_ctl_o <= 3'h0;
      out_b_sprite_en_o <= 1'b0;
      out_b_screen_bg_en_o <= 1'b0;
      out_b_row_bg_en_o <= 1'b0;
      out_b_char_ctl_o <= 3'h0;
      out_c_sprite_en_o <= 1'b0;
      out_c_screen_bg_en_o <= 1'b0;
      out_c_row_bg_en_o <= 1'b0;
      out_c_char_ctl_o <= 3'h0;
    end else if (cmd_valid_i && cmd.grp == GRP_SCREEN) begin
      if (cmd_out.sub == SUB_OUT_A) begin
        sprite_out_en_o <= cmd_out.sprite_en;
        screen_bg_en_o <= cmd_out.screen_bg_en;
        display_out_en_o <= cmd_out.disp_en;
        out_a_char_ctl_o <= cmd_out.char_ctl;
      end else if (cmd_out.sub == SUB_OUT_B) begin
        out_b_sprite_en_o <= cmd_out.sprite_en;
        out_b_screen_bg_en_o <= cmd_out.screen_bg_en;
        out_b_row_bg_en_o <= cmd_out.row_bg_en;
        out_b_char_ctl_o <= cmd_out.char_ctl;
      end else if (cmd_out.sub == SUB_OUT_C) begin
        out_c_sprite_en_o <= cmd_out.sprite_en;
        out_c_screen_bg_en_o <= cmd_out.screen_bg_en;
        out_c_row_bg_en_o <= cmd_out.row_bg_en;
        out_c_char_ctl_o <= cmd_out.char_ctl;
      end
    end
  end

  // Display position controls
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vert_position_o <= 9'h000;
      horiz_position_o <= 9'h000;
    end else if (cmd_valid_i && cmd.grp == GRP_SCREEN) begin
      if (cmd_pos.sub == SUB_VPOS) begin
        vert_position_o <= cmd_pos.pos;
      end else if (cmd_pos.sub == SUB_HPOS) begin
        horiz_position_o <= cmd_pos.pos;
      end
    end
  end

  // Sprite appearance controls
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sprite_trim_ctl_o <= 2'h0;
      sprite_trim_color_o <= 4'h0;
      sprite_color_o <= 4'h0;
      sprite_shape_sel_o <= 2'h0;
      sprite_code_o <= 8'h00;
    end else if (cmd_valid_i && cmd.grp == GRP_SPRITE_A) begin
      if (cmd_spr.sub == SUB_SPR_COLOR) begin
        {sprite_trim_ctl_o, sprite_trim_color_o, sprite_color_o} <= cmd_spr.body;
      end else if (cmd_spr.sub == SUB_SPR_CODE) begin
        {sprite_shape_sel_o, sprite_code_o} <= cmd_spr.body;
      end
    end
  end

  // Sprite position controls
  // unmatched subcodes fall through
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sprite_vpos_o <= 10'h000;
      sprite_hpos_o <= 10'h000;
    end else if (cmd_valid_i && cmd.grp == GRP_SPRITE_B) begin
      if (cmd_spr.sub == SUB_SPR_VPOS) begin
        sprite_vpos_o <= cmd_spr.body;
      end else if (cmd_spr.sub == SUB_SPR_HPOS) begin
        sprite_hpos_o <= cmd_spr.body;
      end
    end
  end

endmodule

//--- common/osd_pkg.sv
// Command layouts, group codes and geometry shared by the display command decoder
package osd_pkg;

  // Command group codes in bits 15 to 12
  localparam logic [3:0] GRP_ADDR = 4'h0;
  localparam logic [3:0] GRP_CHAR_ATTR = 4'h1;
  localparam logic [3:0] GRP_CHAR_WRITE = 4'h2;
  localparam logic [3:0] GRP_ROW_ATTR = 4'h3;
  localparam logic [3:0] GRP_ROW_WRITE = 4'h4;
  localparam logic [3:0] GRP_SCREEN = 4'h5;
  localparam logic [3:0] GRP_SPRITE_A = 4'h8;
  localparam logic [3:0] GRP_SPRITE_B = 4'h9;

  // Subcodes of the screen and sprite groups
  localparam logic [3:0] SUB_OUT_A = 4'h0;
  localparam logic [3:0] SUB_OUT_B = 4'h1;
  localparam logic [3:0] SUB_OUT_C = 4'h2;
  localparam logic [2:0] SUB_VPOS = 3'h4;
  localparam logic [2:0] SUB_HPOS = 3'h6;
  localparam logic [1:0] SUB_SPR_COLOR = 2'h0;
  localparam logic [1:0] SUB_SPR_CODE = 2'h1;
  localparam logic [1:0] SUB_SPR_VPOS = 2'h0;
  localparam logic [1:0] SUB_SPR_HPOS = 2'h2;

  // Display memory geometry
  localparam int CHAR_ROWS = 12;
  localparam int CHAR_COLS = 28;
  localparam int CHAR_CELLS = CHAR_ROWS * CHAR_COLS;
  localparam logic [3:0] LAST_ROW = 4'hB;
  localparam logic [4:0] LAST_COL = 5'h1B;
  localparam logic [8:0] LAST_CELL = 9'h14F;
  localparam logic [8:0] COLS_W9 = 9'h01C;

  // Generic layout: group, 12-bit payload
  typedef struct packed {logic [3:0] grp; logic [11:0] body;} osd_cmd_t;
  typedef struct packed {
    logic [3:0] grp; logic [3:0] row; logic fill; logic [1:0] zero; logic [4:0] col;
  } osd_addr_cmd_t;
  typedef struct packed {logic [3:0] grp; logic [3:0] sub; logic [7:0] body;} osd_scr_cmd_t;
  typedef struct packed {
    logic [3:0] grp; logic [3:0] sub; logic sprite_en; logic screen_bg_en; logic row_bg_en;
    logic disp_en; logic zero; logic [2:0] char_ctl;
  } osd_out_cmd_t;
  typedef struct packed {logic [3:0] grp; logic [2:0] sub; logic [8:0] pos;} osd_pos_cmd_t;
  typedef struct packed {logic [3:0] grp; logic [1:0] sub; logic [9:0] body;} osd_spr_cmd_t;

  // Staged attribute layouts held in display memory
  typedef struct packed {
    logic [1:0] char_out_ctl; logic [1:0] char_bg_ctl; logic [3:0] char_bg_color; logic [3:0] char_color;
  } osd_char_attr_t;
  typedef struct packed {logic char_bg_join; logic char_width_sel; logic [9:0] char_code;} osd_char_fld_t;
  typedef struct packed {
    logic row_height_sel; logic [2:0] row_spacing; logic [1:0] trim_out_ctl; logic [1:0] trim_ctl;
    logic [3:0] trim_color;
  } osd_row_attr_t;
  typedef struct packed {
    logic row_out_en; logic enlarge_interp; logic [1:0] enlarge_ctl; logic row_bg_join; logic bg_extend;
    logic [1:0] row_bg_ctl; logic [3:0] row_bg_color;
  } osd_row_fld_t;

  // Write engine states
  typedef enum logic [1:0] {ST_IDLE, ST_PEND_CHAR, ST_PEND_ROW, ST_FILL} osd_state_t;

  // Reset synchroniser preset for the dot clock domain
  localparam logic [1:0] DOT_RST_ON = 2'h3;

endpackage

//--- testbench/osd_cmd_decoder_asserts.sv
// Port-level checks for the display command decoder
`timescale 1ns/1ps
module osd_cmd_decoder_asserts
  import osd_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command port
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_word_i,
  // Watched outputs
  input wire logic busy_o,
  input wire logic line_sync_o,
  input wire logic [3:0] wr_row_o,
  input wire logic [4:0] wr_col_o,
  input wire logic fill_enable_o,
  input wire logic sprite_out_en_o,
  input wire logic screen_bg_en_o,
  input wire logic display_out_en_o,
  input wire logic [2:0] out_a_char_ctl_o,
  input wire logic [8:0] vert_position_o,
  input wire logic [9:0] sprite_vpos_o
);
  // Short views of the command and settings
  wire logic v = cmd_valid_i;
  wire logic [15:0] w = cmd_word_i;
  wire logic [5:0] outa = {sprite_out_en_o, screen_bg_en_o, display_out_en_o, out_a_char_ctl_o};
  wire logic [24:0] sets = {outa, vert_position_o, sprite_vpos_o};
  wire logic wr_cmd = v && (w[15:12] == GRP_CHAR_WRITE) && !busy_o;
  // Undefined groups and screen subcodes 3 and 101
  wire logic bad = v && (w[15:12] inside {4'h6, 4'h7, [4'hA:4'hF]} || w[15:8] == 8'h53 || w[15:9] == 7'h2D);

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  addr_load_a: assert property (v && w[15:12] == GRP_ADDR && w[6:5] == 2'h0 |=>
    {wr_row_o, fill_enable_o, wr_col_o} == $past({w[11:7], w[4:0]})) else $error("address load wrong");
  out_a_load_a: assert property (v && w[15:8] == 8'h50 |=>
    outa == $past({w[7:6], w[4], w[2:0]})) else $error("output A settings wrong");
  vert_pos_a: assert property (v && w[15:9] == 7'h2C |=> vert_position_o == $past(w[8:0]))
    else $error("vertical position wrong");
  spr_vpos_a: assert property (v && w[15:10] == 6'h24 |=> sprite_vpos_o == $past(w[9:0]))
    else $error("sprite vertical position wrong");
  sync_stall_a: assert property (busy_o && line_sync_o |=> busy_o) else $error("write ran during line sync");
  write_busy_a: assert property (wr_cmd |=> busy_o) else $error("write not pending");
  col_step_a: assert property (wr_cmd && !fill_enable_o && wr_col_o < LAST_COL ##1 !line_sync_o |=>
    wr_col_o == $past(wr_col_o, 2) + 5'h01) else $error("column did not advance");
  row_keep_a: assert property (v && w[15:12] == GRP_ROW_WRITE ##1 !v |=>
    {wr_row_o, wr_col_o} == $past({wr_row_o, wr_col_o}, 2)) else $error("row write moved address");
  reset_clear_a: assert property ($fell(rst_i) |-> outa[5:3] == 3'h0) else $error("enables not cleared");
  ignore_cmd_a: assert property (bad |=> $stable(sets)) else $error("undefined word changed settings");

  // Main scenarios reached
  fill_c: cover property (wr_cmd && fill_enable_o);
  stall_c: cover property (busy_o && line_sync_o);
  wrap_c: cover property (wr_cmd && wr_col_o == LAST_COL && wr_row_o == LAST_ROW);
endmodule

bind osd_cmd_decoder osd_cmd_decoder_asserts u_chk (.clk_i, .rst_i, .cmd_valid_i, .cmd_word_i, .busy_o, .line_sync_o,
  .wr_row_o, .wr_col_o, .fill_enable_o, .sprite_out_en_o, .screen_bg_en_o, .display_out_en_o, .out_a_char_ctl_o,
  .vert_position_o, .sprite_vpos_o);

//--- testbench/osd_sync_source.sv
// Sync source model: free dot clock, line and frame sync pins
`timescale 1ns/1ps
module osd_sync_source (
  // Pin polarity select
  input wire logic pol_i,
  // Dot clock and sync pins
  output logic dot_clk_o,
  output logic line_o,
  output logic frame_o,
  // Active-high line pulse for the bench
  output logic line_act_o
);
  int dot = 0;
  int line = 0;
  logic frame_act = 1'b0;
  // dot clock free, also in reset
  initial begin
    dot_clk_o = 1'b0;
    #7;
    forever #15 dot_clk_o = ~dot_clk_o;
  end
  // Pins move on the falling dot edge, away from sampling
  always @(negedge dot_clk_o) begin
    dot <= (dot == 63) ? 0 : dot + 1;
    if (dot == 63) line <= (line == 9) ? 0 : line + 1;
    if (dot == 8) frame_act <= (line < 2);
  end
  assign line_act_o = (dot < 18);
  assign line_o = pol_i ? line_act_o : !line_act_o;
  assign frame_o = pol_i ? frame_act : !frame_act;
endmodule

//--- testbench/tb.sv
// Self-checking bench for the display command decoder
`timescale 1ns/1ps
module tb;
  import osd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic [15:0] cmd_word_i = 16'h0000;
  logic sync_polarity_sel_i = 1'b0;
  logic [3:0] rd_row_i = 4'h0;
  logic [4:0] rd_col_i = 5'h00;
  wire logic dot_clk, line_pin, frame_pin, line_act;
  logic [23:0] rd_char_data_o, rd_row_data_o;
  logic busy_o, line_sync_o, frame_sync_o, fill_enable_o, sprite_out_en_o, screen_bg_en_o, display_out_en_o;
  logic out_b_sprite_en_o, out_b_screen_bg_en_o, out_b_row_bg_en_o;
  logic out_c_sprite_en_o, out_c_screen_bg_en_o, out_c_row_bg_en_o;
  logic [2:0] out_a_char_ctl_o, out_b_char_ctl_o, out_c_char_ctl_o;
  logic [8:0] vert_position_o, horiz_position_o;
  logic [1:0] sprite_trim_ctl_o, sprite_shape_sel_o;
  logic [3:0] wr_row_o, sprite_trim_color_o, sprite_color_o;
  logic [4:0] wr_col_o;
  logic [7:0] sprite_code_o;
  logic [9:0] sprite_vpos_o, sprite_hpos_o;
  int err_count = 0;
  int n_compared = 0;
  int lastwait = 0;
  // Model state: settings, address, staging and memory
  logic [75:0] mset = '0;
  int mr = 0;
  int mc = 0;
  logic mf = 1'b0;
  logic [11:0] mca, mra;
  logic [23:0] mchar [CHAR_CELLS];
  logic [23:0] mrow [CHAR_ROWS];
  logic [15:0] seed = 16'h004B;
  // Prefixes and free bits; the last seven are undefined words
  logic [15:0] pfx [16] = '{16'h5000, 16'h5100, 16'h5200, 16'h5800, 16'h5C00, 16'h8000, 16'h8400, 16'h9000,
    16'h9800, 16'h5300, 16'h5A00, 16'h5E00, 16'h8800, 16'h9400, 16'h9C00, 16'h0060};
  logic [15:0] msk [16] = '{16'h00D7, 16'h00E7, 16'h00E7, 16'h01FF, 16'h01FF, 16'h03FF, 16'h03FF, 16'h03FF,
    16'h03FF, 16'h00FF, 16'h01FF, 16'h01FF, 16'h03FF, 16'h03FF, 16'h03FF, 16'h0F9F};
  wire logic [75:0] gset = {sprite_out_en_o, screen_bg_en_o, display_out_en_o, out_a_char_ctl_o, out_b_sprite_en_o,
    out_b_screen_bg_en_o, out_b_row_bg_en_o, out_b_char_ctl_o, out_c_sprite_en_o, out_c_screen_bg_en_o,
    out_c_row_bg_en_o, out_c_char_ctl_o, vert_position_o, horiz_position_o, sprite_trim_ctl_o,
    sprite_trim_color_o, sprite_color_o, sprite_shape_sel_o, sprite_code_o, sprite_vpos_o, sprite_hpos_o};

  always #4 clk_i = ~clk_i;

  osd_cmd_decoder dut (.clk_i, .rst_i, .cmd_valid_i, .cmd_word_i, .sync_polarity_sel_i, .dot_clk_in_i(dot_clk),
    .line_sync_i(line_pin), .frame_sync_i(frame_pin), .rd_row_i, .rd_col_i, .rd_char_data_o, .rd_row_data_o,
    .busy_o, .line_sync_o, .frame_sync_o, .wr_row_o, .wr_col_o, .fill_enable_o, .sprite_out_en_o, .screen_bg_en_o,
    .display_out_en_o, .out_a_char_ctl_o, .out_b_sprite_en_o, .out_b_screen_bg_en_o, .out_b_row_bg_en_o,
    .out_b_char_ctl_o, .out_c_sprite_en_o, .out_c_screen_bg_en_o, .out_c_row_bg_en_o, .out_c_char_ctl_o,
    .vert_position_o, .horiz_position_o, .sprite_trim_ctl_o, .sprite_trim_color_o, .sprite_color_o,
    .sprite_shape_sel_o, .sprite_code_o, .sprite_vpos_o, .sprite_hpos_o);
  osd_sync_source u_sync (.pol_i(sync_polarity_sel_i), .dot_clk_o(dot_clk), .line_o(line_pin), .frame_o(frame_pin),
    .line_act_o(line_act));

  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Settings, address and fill flag against the model
  task automatic chk_set(string n);
    n_compared++;
    if ({wr_row_o, fill_enable_o, wr_col_o, gset} !== {4'(mr), mf, 5'(mc), mset}) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, {4'(mr), mf, 5'(mc), mset}, {wr_row_o, fill_enable_o, wr_col_o, gset});
    end
  endtask

  // Memory read; data is registered, so look one cycle later
  task automatic chk_rd(int r, int c);
    @(negedge clk_i);
    rd_row_i = 4'(r);
    rd_col_i = 5'(c);
    @(negedge clk_i);
    n_compared++;
    if ({rd_char_data_o, rd_row_data_o} !== {mchar[r * CHAR_COLS + c], mrow[r]}) begin
      err_count++;
      $display("BAD read %0d %0d exp %h %h got %h %h", r, c, mchar[r * CHAR_COLS + c], mrow[r], rd_char_data_o,
        rd_row_data_o);
    end
  endtask

  task automatic chk_bit(string n, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask

  // One-cycle command pulse, model update, then wait for idle
  task automatic send(logic [15:0] w);
    int i;
    @(negedge clk_i);
    cmd_valid_i = 1'b1;
    cmd_word_i = w;
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    case (w[15:12])
      4'h0: if (w[6:5] == 2'h0) {mr, mf, mc} = {28'h0, w[11:8], w[7], 27'h0, w[4:0]};
      4'h1: mca = w[11:0];
      4'h2: begin
        if (mf) begin
          for (i = 0; i < CHAR_CELLS; i++) mchar[i] = {mca, w[11:0]};
        end else begin
          mchar[mr * CHAR_COLS + mc] = {mca, w[11:0]};
          mc = (mc == 27) ? 0 : mc + 1;
          if (mc == 0) mr = (mr == 11) ? 0 : mr + 1;
        end
      end
      4'h3: mra = w[11:0];
      4'h4: mrow[mr] = {mra, w[11:0]};
      4'h5: begin
        if (w[11:8] == 4'h0) mset[75:70] = {w[7:6], w[4], w[2:0]};
        if (w[11:8] == 4'h1) mset[69:64] = {w[7:5], w[2:0]};
        if (w[11:8] == 4'h2) mset[63:58] = {w[7:5], w[2:0]};
        if (w[11:9] == 3'h4) mset[57:49] = w[8:0];
        if (w[11:9] == 3'h6) mset[48:40] = w[8:0];
      end
      4'h8: if (w[11:10] == 2'h0) mset[39:30] = w[9:0]; else if (w[11:10] == 2'h1) mset[29:20] = w[9:0];
      4'h9: if (w[11:10] == 2'h0) mset[19:10] = w[9:0]; else if (w[11:10] == 2'h2) mset[9:0] = w[9:0];
      default: ;
    endcase
    for (lastwait = 0; lastwait < 3000 && busy_o !== 1'b0; lastwait++) @(negedge clk_i);
    if (lastwait >= 3000) err_count++;
  endtask

  // Wait for a fresh line pulse edge, then let it cross over
  task automatic wait_act(logic t);
    int k;
    for (k = 0; k < 2000 && line_act !== !t; k++) @(negedge clk_i);
    if (k >= 2000) err_count++;
    for (k = 0; k < 2000 && line_act !== t; k++) @(negedge clk_i);
    if (k >= 2000) err_count++;
    repeat (40) @(negedge clk_i);
  endtask

  initial begin
    int i;
    int g;
    repeat (125) @(negedge clk_i);
    rst_i = 1'b0;
    chk_set("reset");
    for (i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      send(pfx[i % 16] | (seed & msk[i % 16]));
      chk_set("setting");
    end
    for (g = 6; g < 16; g++) begin
      seed = lfsr(seed);
      if (g != 8 && g != 9) send({4'(g), seed[11:0]});
      chk_set("unused group");
    end
    send(16'h50D7);
    chk_set("enables on");
    rst_i = 1'b1;
    repeat (125) @(negedge clk_i);
    rst_i = 1'b0;
    mset = '0;
    {mr, mc, mf} = '0;
    chk_set("reset again");
    $display("test settings done");
    send(16'h0080);
    seed = lfsr(seed);
    send({4'h1, seed[11:0]});
    send({4'h2, seed[15:4]});
    chk_set("fill");
    for (i = 0; i < 12; i++) chk_rd(i, 27 - 2 * i);
    send(16'h0000);
    $display("test fill done");
    for (i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      send({4'h0, 4'(i), 8'(i)});
      send({4'h3, seed[11:0]});
      send({4'h4, seed[15:4]});
      chk_set("row write");
      chk_rd(i, i);
    end
    $display("test rows done");
    send(16'h0B1A);
    for (i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      send({4'h1, seed[11:0]});
      send({4'h2, seed[15:4]});
      chk_set("char write");
    end
    chk_rd(11, 26);
    chk_rd(11, 27);
    chk_rd(0, 0);
    // write held off by line sync
    wait_act(1'b1);
    send(16'h2ABC);
    chk_bit("stall", 1'b1, lastwait > 20);
    chk_rd(0, 1);
    $display("test writes done");
    for (g = 0; g < 2; g++) begin
      sync_polarity_sel_i = g[0];
      wait_act(1'b1);
      chk_bit("line active", 1'b1, line_sync_o);
      wait_act(1'b0);
      chk_bit("line idle", 1'b0, line_sync_o);
      chk_bit("frame level", g[0] ? frame_pin : !frame_pin, frame_sync_o);
    end
    $display("test polarity done");
    results();
  end

  // Watchdog far beyond the expected few thousand cycles
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule
